// ==== hdl/sdra_map.vh ====
// Constants for the scan debug register access block
`ifndef SDRA_MAP_VH
`define SDRA_MAP_VH
`define SDRA_CMD_W 10
`define SDRA_CMD_RW_BIT 9
`define SDRA_CMD_GO_BIT 8
`define SDRA_CMD_EXIT_BIT 7
`define SDRA_RSEL_MSB 6
`define SDRA_RSEL_W 7
`define SDRA_RSEL_BYPASS 7'h11
`define SDRA_RSEL_CTRL 7'h12
`define SDRA_RSEL_EVSTAT 7'h30
`define SDRA_RSEL_DBGCTL0 7'h31
`define SDRA_RSEL_SCAN 7'h10
`define SDRA_DATA_W 32
`define SDRA_EDE_BIT 31
`define SDRA_DBGCTL0_RST 32'h00000000
`define SDRA_EVSTAT_RST 32'h00000000
`define SDRA_CTRL_W 32
`define SDRA_CTRL_HALT_BIT 0
`define SDRA_CTRL_WAKE_BIT 2
`define SDRA_CTRL_BRK_BIT 1
`define SDRA_STAT_FIXED 10'h001
`define SDRA_STAT_CLK_BIT 9
`define SDRA_STAT_HALT_BIT 3
`define SDRA_TAP_RESET 16'h0001
`define SDRA_TAP_IDLE 16'h0002
`define SDRA_TAP_SEL_DR 16'h0004
`define SDRA_TAP_CAP_DR 16'h0008
`define SDRA_TAP_SH_DR 16'h0010
`define SDRA_TAP_EX1_DR 16'h0020
`define SDRA_TAP_PA_DR 16'h0040
`define SDRA_TAP_EX2_DR 16'h0080
`define SDRA_TAP_UPD_DR 16'h0100
`define SDRA_TAP_SEL_IR 16'h0200
`define SDRA_TAP_CAP_IR 16'h0400
`define SDRA_TAP_SH_IR 16'h0800
`define SDRA_TAP_EX1_IR 16'h1000
`define SDRA_TAP_PA_IR 16'h2000
`define SDRA_TAP_EX2_IR 16'h4000
`define SDRA_TAP_UPD_IR 16'h8000
`endif

// ==== hdl/sdra_top.v ====
// Scan debug register access logic behind the test access port
//
// Overview of operation
// - Write command with flag clear stores next data scan into selected register.
// - Read flag set shifts selected register out on tdo during data scan.
// - Ten-bit command, top bit read flag; 0x031 writes debug control zero.
// - Read of bypass target accepted with no register side effects.
// - All scans move least significant bit first on tdi and tdo.
// - Event status and scan chain blocked until external debug enable holds one.
// - Port reset and power-on reset clear enable; processor reset keeps it.
// - Other control zero bits clear on processor or power-on reset.
// - Enable is bit 0 msb-first, bit 31 here; 0x80000000 sets it.
// - First control zero write only changes enable; others need enable set.
// - Core status latched into status register at the tck rise in Capture-IR.
// - Ten-bit status shifts out on tdo during Shift-IR with command in.
// - Halt request bit set forces core into halted debug mode.
// - Wake request bit set keeps core clock running.
// - Status flags show halted state and core clock activity.
// - Breakpoint recognition bit enables software breakpoint recognition.
// - Writing ones to event status clears the matching flags.
// - Core state chain scanned and updated after halt before exit or step.
// - Select 0x31 addresses control zero; 0x11 addresses bypass.
// - Exit request leaves debug mode on entering Update-DR.
// - Writes to read-only registers ignored.
`timescale 1ns/1ps
`default_nettype none
`include "sdra_map.vh"
module sdra_top (
    // Clock and resets
    input wire sys_clk_i,
    input wire rstn_i,
    input wire port_rstn_i,
    input wire cpu_rstn_i,
    // Test access port pins
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    output reg tdo_o,
    output reg tdo_oe_o,
    // Core side
    input wire core_halted_i,
    input wire core_clk_active_i,
    input wire [`SDRA_DATA_W-1:0] event_set_i,
    output reg halt_req_o,
    output reg wake_req_o,
    output reg brk_enable_o,
    output reg exit_req_o,
    output reg scan_update_o,
    output reg ext_debug_o
);
    // Pin sync: three stages, change counted when stages two and three agree
    reg [2:0] tck_s_q, tms_s_q, tdi_s_q;
    reg tck_v_q, tms_v_q, tdi_v_q;
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tck_s_q <= 3'h0;
            tms_s_q <= 3'h0;
            tdi_s_q <= 3'h0;
            tck_v_q <= 1'b0;
            tms_v_q <= 1'b1;
            tdi_v_q <= 1'b0;
        end else begin
            tck_s_q <= {tck_s_q[1:0], tck_i};
            tms_s_q <= {tms_s_q[1:0], tms_i};
            tdi_s_q <= {tdi_s_q[1:0], tdi_i};
            if (tck_s_q[1] == tck_s_q[2]) begin
                tck_v_q <= tck_s_q[2];
            end
            if (tms_s_q[1] == tms_s_q[2]) begin
                tms_v_q <= tms_s_q[2];
            end
            if (tdi_s_q[1] == tdi_s_q[2]) begin
                tdi_v_q <= tdi_s_q[2];
            end
        end
    end
    wire rise = tck_s_q[1] & tck_s_q[2] & ~tck_v_q;
    wire fall = ~tck_s_q[1] & ~tck_s_q[2] & tck_v_q;

    // TAP state machine, one-hot
    localparam [15:0] ST_RESET = `SDRA_TAP_RESET;
    localparam [15:0] ST_IDLE = `SDRA_TAP_IDLE;
    localparam [15:0] ST_SEL_DR = `SDRA_TAP_SEL_DR;
    localparam [15:0] ST_CAP_DR = `SDRA_TAP_CAP_DR;
    localparam [15:0] ST_SH_DR = `SDRA_TAP_SH_DR;
    localparam [15:0] ST_EX1_DR = `SDRA_TAP_EX1_DR;
    localparam [15:0] ST_PA_DR = `SDRA_TAP_PA_DR;
    localparam [15:0] ST_EX2_DR = `SDRA_TAP_EX2_DR;
    localparam [15:0] ST_UPD_DR = `SDRA_TAP_UPD_DR;
    localparam [15:0] ST_SEL_IR = `SDRA_TAP_SEL_IR;
    localparam [15:0] ST_CAP_IR = `SDRA_TAP_CAP_IR;
    localparam [15:0] ST_SH_IR = `SDRA_TAP_SH_IR;
    localparam [15:0] ST_EX1_IR = `SDRA_TAP_EX1_IR;
    localparam [15:0] ST_PA_IR = `SDRA_TAP_PA_IR;
    localparam [15:0] ST_EX2_IR = `SDRA_TAP_EX2_IR;
    localparam [15:0] ST_UPD_IR = `SDRA_TAP_UPD_IR;
    reg [15:0] tap_q, tap_d;
    always @* begin
        case (tap_q)
            ST_RESET:
                tap_d = tms_v_q ? ST_RESET : ST_IDLE;
            ST_IDLE:
                tap_d = tms_v_q ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR:
                tap_d = tms_v_q ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR:
                tap_d = tms_v_q ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:
                tap_d = tms_v_q ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR:
                tap_d = tms_v_q ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:
                tap_d = tms_v_q ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR:
                tap_d = tms_v_q ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR:
                tap_d = tms_v_q ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR:
                tap_d = tms_v_q ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR:
                tap_d = tms_v_q ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:
                tap_d = tms_v_q ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR:
                tap_d = tms_v_q ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:
                tap_d = tms_v_q ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR:
                tap_d = tms_v_q ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR:
                tap_d = tms_v_q ? ST_SEL_DR : ST_IDLE;
            default:
                tap_d = ST_RESET;
        endcase
    end

    reg [`SDRA_CMD_W-1:0] ir_sh_q, cmd_q;
    reg [`SDRA_DATA_W-1:0] dr_sh_q, evst_q, ctrl_q;
    // Enable bit and the rest live in separate reset domains
    reg ede_q;
    reg [`SDRA_EDE_BIT-1:0] ctl0_lo_q;
    localparam [`SDRA_DATA_W-1:0] CTL0_RST = `SDRA_DBGCTL0_RST;
    wire [`SDRA_DATA_W-1:0] ctl0_q = {ede_q, ctl0_lo_q};
    wire [`SDRA_RSEL_W-1:0] rsel = cmd_q[`SDRA_RSEL_MSB:0];
    // top bit is the read flag
    wire cmd_rd = cmd_q[`SDRA_CMD_RW_BIT];
    wire ede = ede_q;
    wire open_ok = ede || rsel == `SDRA_RSEL_DBGCTL0 ||
        rsel == `SDRA_RSEL_CTRL || rsel == `SDRA_RSEL_BYPASS;
    reg [`SDRA_DATA_W-1:0] rd_val;
    always @* begin
        case (rsel)
            `SDRA_RSEL_DBGCTL0: rd_val = ctl0_q;
            `SDRA_RSEL_EVSTAT: rd_val = ede ? evst_q : `SDRA_EVSTAT_RST;
            `SDRA_RSEL_CTRL: rd_val = ctrl_q;
            default: rd_val = `SDRA_EVSTAT_RST;
        endcase
    end
    wire [`SDRA_CMD_W-1:0] stat_now = `SDRA_STAT_FIXED |
        ({{(`SDRA_CMD_W-1){1'b0}}, core_clk_active_i} << `SDRA_STAT_CLK_BIT) |
        ({{(`SDRA_CMD_W-1){1'b0}}, core_halted_i} << `SDRA_STAT_HALT_BIT);
    wire upd_dr = rise && tap_q == ST_EX1_DR && tms_v_q ||
        rise && tap_q == ST_EX2_DR && tms_v_q;
    wire wr_go = upd_dr && !cmd_rd && open_ok;

    // Shift paths and command register on tck rising edges
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tap_q <= ST_RESET;
            ir_sh_q <= {`SDRA_CMD_W{1'b0}};
            dr_sh_q <= {`SDRA_DATA_W{1'b0}};
            cmd_q <= {1'b1, 2'h0, `SDRA_RSEL_BYPASS};
        end else if (rise) begin
            tap_q <= tap_d;
            case (tap_q)
                ST_CAP_IR: ir_sh_q <= stat_now;
                ST_SH_IR: ir_sh_q <= {tdi_v_q, ir_sh_q[`SDRA_CMD_W-1:1]};
                ST_CAP_DR: dr_sh_q <= (cmd_rd && open_ok) ? rd_val :
                    {`SDRA_DATA_W{1'b0}};
                ST_SH_DR: dr_sh_q <= {tdi_v_q, dr_sh_q[`SDRA_DATA_W-1:1]};
                default: ir_sh_q <= ir_sh_q;
            endcase
            if (tap_d == ST_UPD_IR) begin
                cmd_q <= ir_sh_q;
            end
        end
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ede_q <= CTL0_RST[`SDRA_EDE_BIT];
        end else if (!port_rstn_i) begin
            ede_q <= CTL0_RST[`SDRA_EDE_BIT];
        end else if (wr_go && rsel == `SDRA_RSEL_DBGCTL0) begin
            ede_q <= dr_sh_q[`SDRA_EDE_BIT];
        end
    end
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl0_lo_q <= CTL0_RST[`SDRA_EDE_BIT-1:0];
        end else if (!cpu_rstn_i) begin
            ctl0_lo_q <= CTL0_RST[`SDRA_EDE_BIT-1:0];
        end else if (wr_go && rsel == `SDRA_RSEL_DBGCTL0 && ede) begin
            ctl0_lo_q <= dr_sh_q[`SDRA_EDE_BIT-1:0];
        end
    end
    reg [`SDRA_DATA_W-1:0] evst_d;
    always @* begin
        evst_d = evst_q | event_set_i;
        // A new event in the clearing cycle must not be lost
        if (wr_go && rsel == `SDRA_RSEL_EVSTAT) begin
            evst_d = (evst_q & ~dr_sh_q) | event_set_i;
        end
    end
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            evst_q <= `SDRA_EVSTAT_RST;
        end else begin
            evst_q <= evst_d;
        end
    end
    // Control register survives processor reset so halt works in reset
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= {`SDRA_CTRL_W{1'b0}};
        end else if (!port_rstn_i) begin
            ctrl_q <= {`SDRA_CTRL_W{1'b0}};
        end else if (wr_go && rsel == `SDRA_RSEL_CTRL) begin
            ctrl_q <= dr_sh_q;
        end
    end

    // Next tdo from the scan register in use; low outside shifts
    reg tdo_d, tdo_oe_d;
    always @* begin
        tdo_d = 1'b0;
        tdo_oe_d = 1'b0;
        case (tap_q)
            ST_SH_IR: begin
                tdo_d = ir_sh_q[0];
                tdo_oe_d = 1'b1;
            end
            ST_SH_DR: begin
                tdo_d = dr_sh_q[0];
                tdo_oe_d = 1'b1;
            end
            default: begin
                tdo_d = 1'b0;
                tdo_oe_d = 1'b0;
            end
        endcase
    end

    // Outputs on every system clock; tdo and its enable on falling tck
    // Tdo moves on the fall so the tool sees it settled at the rise
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
            halt_req_o <= 1'b0;
            wake_req_o <= 1'b0;
            brk_enable_o <= 1'b0;
            exit_req_o <= 1'b0;
            scan_update_o <= 1'b0;
            ext_debug_o <= 1'b0;
        end else begin
            if (fall) begin
                tdo_oe_o <= tdo_oe_d;
                tdo_o <= tdo_d;
            end
            halt_req_o <= ctrl_q[`SDRA_CTRL_HALT_BIT];
            wake_req_o <= ctrl_q[`SDRA_CTRL_WAKE_BIT];
            brk_enable_o <= ctrl_q[`SDRA_CTRL_BRK_BIT];
            ext_debug_o <= ede;
            // exit on Update-DR, bypass or scan chain only
            exit_req_o <= upd_dr && cmd_q[`SDRA_CMD_GO_BIT] &&
                cmd_q[`SDRA_CMD_EXIT_BIT] && (rsel == `SDRA_RSEL_BYPASS ||
                rsel == `SDRA_RSEL_SCAN);
            scan_update_o <= wr_go && rsel == `SDRA_RSEL_SCAN;
        end
    end
    // no write path exists for the status register
endmodule // sdra_top
`default_nettype wire

// ==== sim/sdra_monitor.sv ====
// Checker for the scan debug register access block
`timescale 1ns/1ps
`default_nettype none
module sdra_monitor (
    // Clock and resets
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic port_rstn_i,
    input wire logic cpu_rstn_i,
    // Pins and core outputs
    input wire logic tck_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic halt_req_o,
    input wire logic wake_req_o,
    input wire logic brk_enable_o,
    input wire logic exit_req_o,
    input wire logic scan_update_o,
    input wire logic ext_debug_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    a_tdo_on_fall: assert property ($changed(tdo_o) |-> !tck_i)
        else $error("tdo moved while tck high");
    a_oe_on_fall: assert property (
        $changed(tdo_oe_o) |-> !tck_i && !$past(tck_i, 2))
        else $error("tdo enable moved off a tck fall");
    a_exit_one_pulse: assert property (
        exit_req_o |-> tck_i ##1 !exit_req_o)
        else $error("exit request not a pulse after tck rise");
    a_scan_one_pulse: assert property (
        scan_update_o |=> !scan_update_o [*2])
        else $error("scan update not a single pulse");
    a_port_clears_ede: assert property (
        !port_rstn_i [*6] |-> !ext_debug_o)
        else $error("port reset left debug enable set");
    a_port_clears_ctl: assert property (
        !port_rstn_i [*6] |-> !(halt_req_o || wake_req_o || brk_enable_o))
        else $error("port reset left control outputs set");
    a_cpu_keeps_ede: assert property (
        $fell(cpu_rstn_i) && port_rstn_i && ext_debug_o |=> ext_debug_o [*4])
        else $error("processor reset cleared debug enable");
    a_reset_quiet: assert property (
        $rose(rstn_i) |-> !(ext_debug_o || halt_req_o || exit_req_o))
        else $error("outputs not clear after power-on reset");
    c_exit: cover property (exit_req_o);
    c_scan: cover property (scan_update_o);
    c_cpu_rst: cover property ($fell(cpu_rstn_i) && ext_debug_o);
endmodule // sdra_monitor
bind sdra_top sdra_monitor mon_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .port_rstn_i(port_rstn_i), .cpu_rstn_i(cpu_rstn_i), .tck_i(tck_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .halt_req_o(halt_req_o),
    .wake_req_o(wake_req_o), .brk_enable_o(brk_enable_o),
    .exit_req_o(exit_req_o), .scan_update_o(scan_update_o),
    .ext_debug_o(ext_debug_o));
`default_nettype wire

// ==== sim/sdra_tb_top.sv ====
// Self-checking bench for the scan debug register access block
`timescale 1ns/1ps
`default_nettype none
module sdra_tb_top;
    logic sys_clk_i = 1'h0, rstn_i = 1'h0, port_rstn_i = 1'h1;
    logic cpu_rstn_i = 1'h1, halted = 1'h0, clk_on = 1'h1;
    logic tck, tms, tdi, tdo, oe, hreq, wreq, brk, exq, supd, ext;
    logic [31:0] ev = 32'h0, r;
    int failures = 0, checks = 0, cyc = 0, nex = 0, nsu = 0;
    initial forever #2 sys_clk_i = ~sys_clk_i;
    sdra_tool tool_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    sdra_top dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .port_rstn_i(port_rstn_i), .cpu_rstn_i(cpu_rstn_i), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe),
        .core_halted_i(halted), .core_clk_active_i(clk_on),
        .event_set_i(ev), .halt_req_o(hreq), .wake_req_o(wreq),
        .brk_enable_o(brk), .exit_req_o(exq), .scan_update_o(supd),
        .ext_debug_o(ext));
    always @(posedge sys_clk_i) begin
        cyc++;
        nex += exq;
        nsu += supd;
        if (cyc == 60000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run;
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [9:0] c, input logic [31:0] d);
        tool_u.scan(1'h1, 10, {22'h0, c}, r);
        tool_u.scan(1'h0, 32, d, r);
    endtask
    task automatic hold(ref logic s);
        @(negedge sys_clk_i) s = 1'h0;
        repeat (8) @(negedge sys_clk_i);
        s = 1'h1;
    endtask
    task automatic t_halt_in_reset;
        tool_u.scan(1'h1, 10, 32'h211, r);
        cmp(r, 32'h201);
        tool_u.scan(1'h0, 32, 32'hFFFFFFFF, r);
        cmp({28'h0, hreq, wreq, brk, ext}, 32'h0);
        @(negedge sys_clk_i) cpu_rstn_i = 1'h0;
        acc(10'h012, 32'h5);
        @(negedge sys_clk_i) cpu_rstn_i = 1'h1;
        cmp({30'h0, hreq, wreq}, 32'h3);
        @(negedge sys_clk_i) halted = 1'h1;
        tool_u.scan(1'h1, 10, 32'h211, r);
        cmp(r, 32'h209);
        acc(10'h012, 32'h6);
        cmp({29'h0, hreq, wreq, brk}, 32'h3);
    endtask
    task automatic t_enable;
        @(negedge sys_clk_i) ev = 32'h1;
        @(negedge sys_clk_i) ev = 32'h0;
        acc(10'h230, 32'h0);
        cmp(r, 32'h0);
        acc(10'h031, 32'hFFFFFFFF);
        cmp({31'h0, ext}, 32'h1);
        acc(10'h231, 32'h0);
        cmp(r, 32'h80000000);
        tool_u.scan(1'h0, 32, 32'h0, r);
        cmp(r, 32'h80000000);
    endtask
    task automatic t_cpu_reset;
        acc(10'h031, 32'hFFFFFFFF);
        acc(10'h231, 32'h0);
        cmp(r, 32'hFFFFFFFF);
        hold(cpu_rstn_i);
        acc(10'h231, 32'h0);
        cmp(r, 32'h80000000);
        cmp({31'h0, ext}, 32'h1);
    endtask
    task automatic t_events_exit;
        @(negedge sys_clk_i) ev = 32'hF;
        @(negedge sys_clk_i) ev = 32'h0;
        acc(10'h230, 32'h0);
        cmp(r, 32'hF);
        acc(10'h030, 32'hFFFFFFFF);
        acc(10'h230, 32'h0);
        cmp(r, 32'h0);
        acc(10'h111, 32'h0);
        acc(10'h191, 32'h0);
        cmp(nex, 32'h1);
        acc(10'h110, 32'h0);
        cmp(nsu, 32'h1);
        acc(10'h212, 32'h0);
        cmp(r, 32'h6);
        hold(port_rstn_i);
        cmp({28'h0, ext, hreq, wreq, brk}, 32'h0);
    endtask
    initial begin
        repeat (16) @(negedge sys_clk_i);
        rstn_i = 1'h1;
        tool_u.step(1'h0, 1'h1, r[0]);
        cmp({26'h0, hreq, wreq, brk, exq, supd, ext}, 32'h0);
        t_halt_in_reset();
        t_enable();
        t_cpu_reset();
        t_events_exit();
        complete_run();
    end
endmodule // sdra_tb_top
`default_nettype wire

// ==== sim/sdra_tool.sv ====
// Debug tool model driving the test access port
`timescale 1ns/1ps
`default_nettype none
module sdra_tool (
    // Test access port
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    // Link clock stands low between frames
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h0;
        tdi_o = 1'h1;
    end
    // One tck period; tdo taken at the rise
    task automatic step(input logic ms, input logic di, output logic dout);
        tck_o = 1'h0;
        tms_o = ms;
        tdi_o = di;
        #62.5 tck_o = 1'h1;
        dout = tdo_i;
        #62.5 tck_o = 1'h0;
    endtask
    // command or data scan, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] v,
        output logic [31:0] res);
        logic x;
        res = 32'h0;
        step(1'h1, tdi_o, x);
        if (ir) step(1'h1, tdi_o, x);
        step(1'h0, tdi_o, x);
        step(1'h0, tdi_o, x);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i], x);
            res[i] = x;
        end
        // Released data line shows the inverse of its last bit
        step(1'h1, ~v[n-1], x);
        step(1'h0, ~v[n-1], x);
    endtask
endmodule // sdra_tool
`default_nettype wire
